// >>> icfu_top.sv
// input capture fifo unit: odd/even capture pair behind an apb slave
//
// Notes on behaviour
// - capture timer on rising or any edge
// - prescaled modes capture every 4th, 16th rise
// - interrupt after programmable capture count
// - fifo-not-empty flag tracks held captures
// - five-bit sync source, zero means none
// - three-bit time base select field
// - trigger-mode bit picks sync or trigger
// - three-bit capture mode field
// - cascade bit set in both pairs modules
// - even module follows odd when cascaded
// - odd module settings govern cascaded pair
// - cascaded pair held reset until sync on
// - capture only with time base and source
// - low half odd buffer, high even
// - odd flag means full pair available
// - modules independent with own 16-bit timer
// - odd wrap increments even count
`timescale 1ns/1ps
`default_nettype none
`include "icfu_consts.svh"
module icfu_top
  import icfu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  capture_input_pin,
  input  wire logic [7:0]  timebase_run,
  input  wire logic [31:0] sync_source_on,
  output logic      [1:0]  capture_irq
);

  // ------------------------------------------------------------
  // decode and read helpers
  // ------------------------------------------------------------
  function automatic logic icfu_hit(input logic [2:0] mode,
                                    input logic       rise,
                                    input logic       fall,
                                    input logic [3:0] pre);
    unique case (mode)
      ICFU_MODE_ANY:   icfu_hit = rise | fall;
      ICFU_MODE_RISE:  icfu_hit = rise;
      ICFU_MODE_DIV4:  icfu_hit = rise & (pre[1:0] == `ICFU_PRE4_LAST);
      ICFU_MODE_DIV16: icfu_hit = rise & (pre == `ICFU_PRE16_LAST);
      default:         icfu_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] icfu_rd(input icfu_con1_t c1,
                                          input icfu_con2_t c2,
                                          input logic       fne,
                                          input logic [15:0] head,
                                          input logic [15:0] tmr,
                                          input logic [3:0] ofs);
    icfu_rd = '0;
    unique case (ofs)
      `ICFU_OFS_CON1: begin
        icfu_rd[`ICFU_C1_TSEL_HI:`ICFU_C1_TSEL_LO] = c1.timebase_clock_select;
        icfu_rd[`ICFU_C1_ICI_HI:`ICFU_C1_ICI_LO] = c1.interrupt_count_select;
        icfu_rd[`ICFU_C1_FNE] = fne;
        icfu_rd[`ICFU_C1_MODE_HI:`ICFU_C1_MODE_LO] = c1.capture_mode_select;
      end
      `ICFU_OFS_CON2: begin
        icfu_rd[`ICFU_C2_CASC]  = c2.cascade_enable;
        icfu_rd[`ICFU_C2_TRIG]  = c2.trigger_mode_select;
        icfu_rd[`ICFU_C2_TSTAT] = c2.trigger_armed_status;
        icfu_rd[`ICFU_C2_SSEL_HI:`ICFU_C2_SSEL_LO] = c2.sync_source_select;
      end
      `ICFU_OFS_BUF: icfu_rd[15:0] = head;
      `ICFU_OFS_TMR: icfu_rd[15:0] = tmr;
      default:       icfu_rd = '0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  icfu_con1_t           con1_q [`ICFU_NCH];
  icfu_con1_t           con1_d [`ICFU_NCH];
  icfu_con2_t           con2_q [`ICFU_NCH];
  icfu_con2_t           con2_d [`ICFU_NCH];
  logic [`ICFU_TW-1:0]  tmr_q  [`ICFU_NCH];
  logic [`ICFU_TW-1:0]  tmr_d  [`ICFU_NCH];
  logic [`ICFU_TW-1:0]  head   [`ICFU_NCH];
  logic [3:0]           pre_q  [`ICFU_NCH];
  logic [3:0]           pre_d  [`ICFU_NCH];
  logic [1:0]           icnt_q [`ICFU_NCH];
  logic [1:0]           icnt_d [`ICFU_NCH];
  logic [1:0]           irq_q, irq_d;
  logic [1:0]           rise, fall, fne, full, push, pop;
  logic [1:0]           run, src_on, hit;
  logic [2:0]           emode  [`ICFU_NCH];
  logic [1:0]           eici   [`ICFU_NCH];
  logic                 casc;
  logic [31:0]          prdata_q, prdata_d;
  logic                 pready_q, pready_d, pslverr_q, pslverr_d;
  logic                 setup, wr_acc, rd_acc, in_map;
  logic                 ch;
  logic [3:0]           ofs;

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign capture_irq = irq_q;

  // ------------------------------------------------------------
  // per-channel pin synchroniser and capture fifo
  // ------------------------------------------------------------
  for (genvar g = 0; g < `ICFU_NCH; g++) begin : g_ch
    icfu_sync u_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_async (capture_input_pin[g]),
      .rise      (rise[g]),
      .fall      (fall[g])
    );
    icfu_fifo u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .push      (push[g]),
      .wdata     (tmr_q[g]),
      .pop       (pop[g]),
      .rdata     (head[g]),
      .not_empty (fne[g]),
      .full      (full[g])
    );
  end

  // ------------------------------------------------------------
  // effective configuration, run control and capture
  // ------------------------------------------------------------
  always_comb begin
    casc = con2_q[0].cascade_enable & con2_q[1].cascade_enable;
    for (int i = 0; i < `ICFU_NCH; i++) begin
      emode[i] = con1_q[i].capture_mode_select;
      eici[i]  = con1_q[i].interrupt_count_select;
      src_on[i] = (con2_q[i].sync_source_select != `ICFU_SSEL_NONE) &&
                  sync_source_on[con2_q[i].sync_source_select];
      // trigger mode waits for armed status, sync mode for the source
      run[i] = (emode[i] != ICFU_MODE_OFF) &&
               timebase_run[con1_q[i].timebase_clock_select] &&
               (con2_q[i].trigger_mode_select ?
                con2_q[i].trigger_armed_status : src_on[i]);
    end
    // even module takes odd settings and run state when paired
    if (casc) begin
      emode[1] = con1_q[0].capture_mode_select;
      eici[1]  = con1_q[0].interrupt_count_select;
      run[1]   = run[0];
    end
    for (int i = 0; i < `ICFU_NCH; i++) begin
      hit[i]  = run[i] & icfu_hit(emode[i], rise[i], fall[i], pre_q[i]);
    end
    push[0] = hit[0];
    push[1] = casc ? hit[0] : hit[1];
  end

  // ------------------------------------------------------------
  // time bases, prescalers and interrupt counters
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `ICFU_NCH; i++) begin
      tmr_d[i]  = run[i] ? tmr_q[i] + 1'b1 : `ICFU_TMR_RST;
      pre_d[i]  = !run[i] ? `ICFU_PRE_RST :
                  (rise[i] ? pre_q[i] + 1'b1 : pre_q[i]);
      icnt_d[i] = icnt_q[i];
      irq_d[i]  = 1'b0;
      if (!run[i]) begin
        icnt_d[i] = `ICFU_ICNT_RST;
      end else if (push[i]) begin
        if (icnt_q[i] == eici[i]) begin
          icnt_d[i] = `ICFU_ICNT_RST;
          irq_d[i]  = 1'b1;
        end else begin
          icnt_d[i] = icnt_q[i] + 1'b1;
        end
      end
    end
    // paired: even count steps on odd wrap, even raises no interrupt
    if (casc) begin
      tmr_d[1] = !run[0] ? `ICFU_TMR_RST :
                 ((tmr_q[0] == `ICFU_TMR_MAX) ? tmr_q[1] + 1'b1
                                              : tmr_q[1]);
      irq_d[1] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= '0;
      for (int i = 0; i < `ICFU_NCH; i++) begin
        tmr_q[i]  <= `ICFU_TMR_RST;
        pre_q[i]  <= `ICFU_PRE_RST;
        icnt_q[i] <= `ICFU_ICNT_RST;
      end
    end else begin
      irq_q <= irq_d;
      for (int i = 0; i < `ICFU_NCH; i++) begin
        tmr_q[i]  <= tmr_d[i];
        pre_q[i]  <= pre_d[i];
        icnt_q[i] <= icnt_d[i];
      end
    end
  end

  // ------------------------------------------------------------
  // apb slave: zero-wait access, read data prepared in setup
  // ------------------------------------------------------------
  always_comb begin
    ch     = paddr[`ICFU_CH_BIT];
    ofs    = paddr[3:0];
    in_map = (paddr < `ICFU_MAP_END) && (paddr[1:0] == 2'h0);
    setup  = psel & ~penable;
    wr_acc = psel & penable & pready_q & pwrite & in_map;
    rd_acc = psel & penable & pready_q & ~pwrite & in_map;
    pready_d  = setup;
    pslverr_d = setup & ~in_map;
    prdata_d  = prdata_q;
    if (setup) begin
      prdata_d = (in_map && !pwrite) ?
                 icfu_rd(con1_q[ch], con2_q[ch], fne[ch], head[ch],
                         tmr_q[ch], ofs) : '0;
    end
    for (int i = 0; i < `ICFU_NCH; i++) begin
      pop[i] = rd_acc && (ch == 1'(i)) && (ofs == `ICFU_OFS_BUF);
      con1_d[i] = con1_q[i];
      con2_d[i] = con2_q[i];
      if (wr_acc && ch == 1'(i) && ofs == `ICFU_OFS_CON1) begin
        con1_d[i].timebase_clock_select  =
          pwdata[`ICFU_C1_TSEL_HI:`ICFU_C1_TSEL_LO];
        con1_d[i].interrupt_count_select =
          pwdata[`ICFU_C1_ICI_HI:`ICFU_C1_ICI_LO];
        con1_d[i].capture_mode_select    =
          pwdata[`ICFU_C1_MODE_HI:`ICFU_C1_MODE_LO];
      end
      if (wr_acc && ch == 1'(i) && ofs == `ICFU_OFS_CON2) begin
        con2_d[i].cascade_enable       = pwdata[`ICFU_C2_CASC];
        con2_d[i].trigger_mode_select  = pwdata[`ICFU_C2_TRIG];
        con2_d[i].trigger_armed_status = pwdata[`ICFU_C2_TSTAT];
        con2_d[i].sync_source_select   =
          pwdata[`ICFU_C2_SSEL_HI:`ICFU_C2_SSEL_LO];
      end
      // trigger arrival sets armed status and beats a clear
      if (con2_q[i].trigger_mode_select && src_on[i]) begin
        con2_d[i].trigger_armed_status = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      for (int i = 0; i < `ICFU_NCH; i++) begin
        con1_q[i] <= '0;
        con2_q[i] <= '0;
      end
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      for (int i = 0; i < `ICFU_NCH; i++) begin
        con1_q[i] <= con1_d[i];
        con2_q[i] <= con2_d[i];
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_edge_capture: assert property (
    push[0] && !full[0] |=> fne[0])
    else $error("capture did not reach the fifo");
  chk_div4_spacing: assert property (
    push[0] && emode[0] == ICFU_MODE_DIV4 |-> pre_q[0][1:0] == 2'h3)
    else $error("divide-by-4 capture off its edge");
  chk_irq_count: assert property (
    push[0] && run[0] && icnt_q[0] == eici[0] |=> irq_q[0] ##1 !irq_q[0])
    else $error("interrupt count not honoured");
  chk_no_source: assert property (
    con2_q[0].sync_source_select == 5'h00 && !con2_q[0].trigger_mode_select
      |-> !run[0])
    else $error("module ran with no sync source");
  chk_trig_wait: assert property (
    con2_q[0].trigger_mode_select && !con2_q[0].trigger_armed_status
      |=> tmr_q[0] == 16'h0000)
    else $error("trigger mode ran before arming");
  chk_even_follow: assert property (
    casc |-> run[1] == run[0])
    else $error("even module not in step with odd");
  chk_casc_hold: assert property (
    casc && !run[0] |=> tmr_q[0] == 16'h0000 && tmr_q[1] == 16'h0000)
    else $error("cascaded pair not held in reset");
  chk_carry_wrap: assert property (
    casc && run[0] && tmr_q[0] == 16'hffff
      |=> tmr_q[1] == $past(tmr_q[1]) + 16'h0001)
    else $error("odd wrap did not carry");
  chk_pair_push: assert property (
    casc && push[0] |-> push[1])
    else $error("cascaded halves pushed apart");
  chk_full_keep: assert property (
    full[0] && !pop[0] |=> full[0])
    else $error("full fifo lost an entry");

  cov_cascade_cap: cover property (casc && push[0]);
  cov_trig_arm:    cover property ($rose(con2_q[0].trigger_armed_status));
  cov_irq_pulse:   cover property (irq_q[0]);
  cov_fifo_full:   cover property (full[0] && push[0]);

endmodule
`default_nettype wire

// >>> icfu_consts.svh
// constants for the input capture fifo unit
`ifndef ICFU_CONSTS_SVH
`define ICFU_CONSTS_SVH

// ------------------------------------------------------------
// structure
// ------------------------------------------------------------
`define ICFU_NCH        2
`define ICFU_TW         16
`define ICFU_FIFO_DEPTH 4
`define ICFU_FIFO_AW    2
`define ICFU_TMR_MAX    16'hffff

// ------------------------------------------------------------
// register map (byte addresses within a channel)
// ------------------------------------------------------------
`define ICFU_OFS_CON1   4'h0
`define ICFU_OFS_CON2   4'h4
`define ICFU_OFS_BUF    4'h8
`define ICFU_OFS_TMR    4'hc
`define ICFU_CH_BIT     4
`define ICFU_MAP_END    8'h20

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ICFU_C1_TSEL_HI 12
`define ICFU_C1_TSEL_LO 10
`define ICFU_C1_ICI_HI  6
`define ICFU_C1_ICI_LO  5
`define ICFU_C1_FNE     3
`define ICFU_C1_MODE_HI 2
`define ICFU_C1_MODE_LO 0
`define ICFU_C2_CASC    8
`define ICFU_C2_TRIG    7
`define ICFU_C2_TSTAT   6
`define ICFU_C2_SSEL_HI 4
`define ICFU_C2_SSEL_LO 0

// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define ICFU_SSEL_NONE  5'h00
`define ICFU_PRE4_LAST  4'h3
`define ICFU_PRE16_LAST 4'hf
`define ICFU_ICNT_RST   2'h0
`define ICFU_PRE_RST    4'h0
`define ICFU_TMR_RST    16'h0000

`endif

// >>> icfu_pkg.sv
// types shared by the input capture fifo unit
package icfu_pkg;

  // capture mode field codes
  typedef enum logic [2:0] {
    ICFU_MODE_OFF   = 3'h0,
    ICFU_MODE_ANY   = 3'h1,
    ICFU_MODE_RISE  = 3'h3,
    ICFU_MODE_DIV4  = 3'h4,
    ICFU_MODE_DIV16 = 3'h5
  } icfu_mode_t;

  // capture_control_one writable fields
  typedef struct packed {
    logic [2:0] timebase_clock_select;
    logic [1:0] interrupt_count_select;
    logic [2:0] capture_mode_select;
  } icfu_con1_t;

  // capture_control_two fields
  typedef struct packed {
    logic       cascade_enable;
    logic       trigger_mode_select;
    logic       trigger_armed_status;
    logic [4:0] sync_source_select;
  } icfu_con2_t;

endpackage

// >>> icfu_sync.sv
// three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module icfu_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_async,
  output logic      rise,
  output logic      fall
);
  logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // level follows only when stages two and three agree
  always_comb begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    rise  = lvl_d & ~lvl_q;
    fall  = ~lvl_d & lvl_q;
  end

  // synchroniser chain; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q  <= pin_async;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end
endmodule
`default_nettype wire

// >>> icfu_fifo.sv
// small capture fifo in flip-flops, drops pushes when full
`timescale 1ns/1ps
`default_nettype none
`include "icfu_consts.svh"
module icfu_fifo (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                push,
  input  wire logic [`ICFU_TW-1:0] wdata,
  input  wire logic                pop,
  output logic      [`ICFU_TW-1:0] rdata,
  output logic                     not_empty,
  output logic                     full
);
  logic [`ICFU_TW-1:0]      mem_q [`ICFU_FIFO_DEPTH];
  logic [`ICFU_FIFO_AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [`ICFU_FIFO_AW:0]   cnt_q, cnt_d;
  logic                     do_push, do_pop;

  // pointer and count update; a full fifo keeps its entries
  always_comb begin
    do_push = push & (cnt_q != `ICFU_FIFO_AW'(0) + (`ICFU_FIFO_AW+1)'(`ICFU_FIFO_DEPTH)) ;
    do_pop  = pop & (cnt_q != '0);
    wp_d    = do_push ? wp_q + 1'b1 : wp_q;
    rp_d    = do_pop ? rp_q + 1'b1 : rp_q;
    cnt_d   = cnt_q + {{`ICFU_FIFO_AW{1'b0}}, do_push}
                    - {{`ICFU_FIFO_AW{1'b0}}, do_pop};
    rdata     = mem_q[rp_q];
    not_empty = (cnt_q != '0);
    full      = (cnt_q == (`ICFU_FIFO_AW+1)'(`ICFU_FIFO_DEPTH));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < `ICFU_FIFO_DEPTH; i++) begin
        mem_q[i] <= `ICFU_TMR_RST;
      end
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      if (do_push) begin
        mem_q[wp_q] <= wdata;
      end
    end
  end
endmodule
`default_nettype wire

// >>> icfu_edge_src.sv
// edge source model standing in for the signal on one capture pin
`timescale 1ns/1ps
`default_nettype none
module icfu_edge_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [7:0]  rises,
  input  wire logic [31:0] half,
  output logic             pin,
  output logic             busy
);
  logic [8:0]  left_q;
  logic [31:0] tmr_q;

  // ---------------------------------------------------------------
  // burst generator
  // ---------------------------------------------------------------
  // sends a burst of rises, each level held for half cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin    <= 1'b0;
      busy   <= 1'b0;
      left_q <= 9'h0;
      tmr_q  <= 32'h0;
    end else if (start && !busy) begin
      busy   <= 1'b1;
      left_q <= {rises, 1'b0};
      tmr_q  <= half;
    end else if (busy) begin
      if (tmr_q > 32'h1) begin
        tmr_q <= tmr_q - 32'h1;
      end else begin
        pin    <= ~pin;  // slow levels keep the input filter happy
        tmr_q  <= half;
        left_q <= left_q - 9'h1;
        busy   <= (left_q != 9'h1);  // burst ends low
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the capture pair behind its apb slave
`timescale 1ns/1ps
`default_nettype none
`include "icfu_consts.svh"
module testbench
  import icfu_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ok;
  logic [7:0]  paddr, timebase_run, rises, b;
  logic [31:0] pwdata, prdata, sync_source_on, half, seed, rd_v, e, h;
  logic [31:0] v [4];
  logic [1:0]  pin, busy, go, capture_irq, ni;
  logic        err_v;
  logic [2:0]  ts;
  icfu_mode_t  md;
  int          mismatches, total_checks, cyc, ch;
  int          irq_n [2];
  icfu_mode_t  mtab [5] = '{ICFU_MODE_ANY, ICFU_MODE_RISE, ICFU_MODE_DIV4,
                            ICFU_MODE_DIV16, ICFU_MODE_RISE};
  logic [7:0]  rtab [5] = '{8'h2, 8'h4, 8'h10, 8'h40, 8'h6};

  icfu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(pin), .timebase_run(timebase_run),
    .sync_source_on(sync_source_on), .capture_irq(capture_irq));
  for (genvar g = 0; g < 2; g++) begin : g_src
    icfu_edge_src src (.pclk(pclk), .presetn(presetn), .start(go[g]),
      .rises(rises), .half(half), .pin(pin[g]), .busy(busy[g]));
  end

  // ---------------------------------------------------------------
  // clock, ceiling and interrupt counting
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // counts cycles and interrupt pulses between edges
  always @(negedge pclk) begin
    cyc++;
    for (int k = 0; k < 2; k++) if (capture_irq[k] === 1'b1) irq_n[k]++;
    if (cyc == 90000) begin
      mismatches++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // capture spacing for a burst whose levels last h cycles
  function automatic logic [31:0] step(input icfu_mode_t m,
                                       input logic [31:0] hh);
    case (m)
      ICFU_MODE_ANY:  return hh;
      ICFU_MODE_RISE: return 2 * hh;
      ICFU_MODE_DIV4: return 8 * hh;
      default:        return 32 * hh;
    endcase
  endfunction
  function automatic logic [31:0] c1(input logic [2:0] t,
                                     input logic [1:0] n,
                                     input logic [2:0] m);
    return {19'h0, t, 3'h0, n, 2'h0, m};
  endfunction
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] y);
    total_checks++;
    if (y !== x) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, x, y);
    end
  endtask
  // one apb transfer, answer taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      ok = (pready === 1'b1);
      rd_v = prdata;
      err_v = pslverr;
    end while (!ok && n < 16);
    if (!ok) chk("pready", 32'h1, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // sends r rises on one pin and lets the synchroniser settle
  task automatic fire(input int c, input logic [7:0] r, input logic [31:0] hh);
    int n;
    n = 0;
    rises <= r;
    half  <= hh;
    go[c] <= 1'b1;
    @(posedge pclk);
    go[c] <= 1'b0;
    do begin
      @(negedge pclk);
      n++;
    end while (busy[c] !== 1'b0 && n < 70000);
    repeat (8) @(posedge pclk);
  endtask
  // reads the buffer until the not-empty flag drops
  task automatic drain(input logic [7:0] bb);
    int n;
    n = 0;
    apb(1'b0, bb, 32'h0);
    while (rd_v[3] !== 1'b0 && n < 8) begin
      apb(1'b0, bb + 8'h8, 32'h0);
      apb(1'b0, bb, 32'h0);
      n++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {go, rises, half, sync_source_on} = '0;
    timebase_run = 8'hff;
    seed = 32'h73b7;
    irq_n = '{0, 0};
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, then refused addresses
    for (int a = 0; a < 32; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset value", 32'h0, rd_v);
    end
    apb(1'b0, `ICFU_MAP_END, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err_v});
    chk("unmapped data", 32'h0, rd_v);
    apb(1'b0, 8'h02, 32'h0);
    chk("misaligned err", 32'h1, {31'h0, err_v});
    chk("misaligned data", 32'h0, rd_v);
    // every capture mode on alternating channels, last one overfills
    for (int i = 0; i < 5; i++) begin
      md = mtab[i];
      ch = i % 2;
      b = 8'(ch * 16);
      seed = xs(seed);
      h = 32'h4 + {29'h0, seed[2:0]};
      ni = seed[4:3];
      ts = seed[7:5];
      timebase_run <= (8'h1 << ts) | seed[15:8];
      sync_source_on <= 32'h0;
      drain(b);
      apb(1'b1, b + 8'h4, 32'h1);
      apb(1'b1, b, c1(ts, ni, 3'h0));
      apb(1'b1, b, c1(ts, ni, md));
      apb(1'b0, b, 32'h0);
      chk("con1 fields", c1(ts, ni, md), rd_v);
      irq_n[ch] = 0;
      sync_source_on <= 32'h2;
      @(posedge pclk);
      fire(ch, rtab[i], h);
      apb(1'b0, b, 32'h0);
      chk("flag set", 32'h1, {31'h0, rd_v[3]});
      for (int k = 0; k < 4; k++) begin
        apb(1'b0, b + 8'h8, 32'h0);
        v[k] = rd_v;
      end
      for (int k = 1; k < 4; k++) begin
        chk("capture step", step(md, h), v[k] - v[k-1]);
      end
      apb(1'b0, b, 32'h0);
      chk("flag clear", 32'h0, {31'h0, rd_v[3]});
      if (i < 4) chk("irq count", 32'(4 / (ni + 1)), 32'(irq_n[ch]));
      sync_source_on <= 32'h0;
      apb(1'b1, b, 32'h0);
    end
    // no capture without a source or without a running time base
    for (int i = 0; i < 2; i++) begin
      timebase_run <= i ? 8'hfe : 8'hff;
      sync_source_on <= 32'hffffffff;
      apb(1'b1, 8'h04, i ? 32'h1 : 32'h0);
      apb(1'b1, 8'h00, c1(3'h0, 2'h0, ICFU_MODE_RISE));
      fire(0, 8'h2, 32'h4);
      apb(1'b0, 8'h0c, 32'h0);
      chk("idle timer", 32'h0, rd_v);
      apb(1'b0, 8'h00, 32'h0);
      chk("idle flag", 32'h0, {31'h0, rd_v[3]});
    end
    // trigger mode keeps running after a one-cycle source pulse
    timebase_run <= 8'hff;
    sync_source_on <= 32'h0;
    apb(1'b1, 8'h04, 32'h83);
    apb(1'b1, 8'h00, c1(3'h0, 2'h0, ICFU_MODE_RISE));
    apb(1'b0, 8'h0c, 32'h0);
    chk("unarmed timer", 32'h0, rd_v);
    sync_source_on <= 32'h8;
    @(posedge pclk);
    sync_source_on <= 32'h0;
    apb(1'b0, 8'h04, 32'h0);
    chk("armed", 32'h1, {31'h0, rd_v[6]});
    apb(1'b0, 8'h0c, 32'h0);
    e = rd_v;
    apb(1'b0, 8'h0c, 32'h0);
    chk("trigger timer", 32'h3, rd_v - e);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    // cascaded pair across a wrap of the low half
    apb(1'b1, 8'h14, 32'h102);
    apb(1'b1, 8'h04, 32'h102);
    apb(1'b1, 8'h10, c1(3'h1, 2'h3, 3'h0));
    apb(1'b1, 8'h00, c1(3'h1, 2'h0, ICFU_MODE_ANY));
    apb(1'b0, 8'h0c, 32'h0);
    chk("held timer", 32'h0, rd_v);
    irq_n = '{0, 0};
    sync_source_on <= 32'h4;
    @(posedge pclk);
    // one pulse: rise before the low half wraps, fall after it
    fire(0, 8'h1, 32'd33000);
    apb(1'b0, 8'h00, 32'h0);
    chk("pair flag", 32'h1, {31'h0, rd_v[3]});
    for (int k = 0; k < 2; k++) begin
      apb(1'b0, 8'h08, 32'h0);
      v[2*k] = rd_v;
      apb(1'b0, 8'h18, 32'h0);
      v[2*k+1] = rd_v;
    end
    chk("pair step", step(ICFU_MODE_ANY, 32'd33000),
        {v[3][15:0], v[2][15:0]} - {v[1][15:0], v[0][15:0]});
    apb(1'b0, 8'h00, 32'h0);
    chk("pair flag clear", 32'h0, {31'h0, rd_v[3]});
    chk("pair irq", 32'h2, 32'(irq_n[0]));
    chk("even irq", 32'h0, 32'(irq_n[1]));
    end_sim();
  end
endmodule
`default_nettype wire
